/* File: design/ioird_core.sv */
`timescale 1ns/1ps
// Behaviour
// - writing the unit identifier also reloads the arbitration identifier
// - arbitration identifier is read-only, bits 27:24, rest reads zero
// - bus winner becomes lowest priority and takes arbitration identifier zero
// - one 64-bit routing entry per pin from index 10h, two 32-bit halves
// - reset sets mask bit 16 and clears bits 15:12 of every entry
// - detected interrupt sets delivery status then waits for bus acknowledge
// - further edges ignored until the bus unit acknowledges the message
// - bit 11 clear: physical id bits 59:56; set: logical set 63:56
// - masked entries neither deliver nor hold interrupts pending
// - masking after acceptance leaves the accepted interrupt untouched
// - bit 15 selects edge (0) or level (1) sensing
// - level entry sets remote-accepted bit 14 on acceptance
// - end-of-service message clears remote-accepted bit 14
// - bit 13 inverts the pin when set, active low
// - delivery status bit 12 is read-only, zero when idle
// - delivery status reads one while the message is held up
// - end-of-service write matches low 8 bits to vectors, clears remote-accepted
// - bits 10:8 give delivery mode; non-maskable is always edge
module ioird_core
  import ioird_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  input  wire ioird_cpu_t       cpu_i,
  output logic [31:0]           rdata_o,
  input  wire logic [NUM_PINS-1:0] irq_pin_i,
  output ioird_msg_t            msg_o,
  output logic                  msg_valid_o,
  input  wire logic             msg_sent_i,
  input  wire logic             msg_accepted_i,
  input  wire logic             arb_won_i,
  input  wire logic             eos_valid_i,
  input  wire logic [7:0]       eos_vector_i
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [63:0]         entry_reg [NUM_PINS];
  logic [7:0]          index_reg;
  logic [3:0]          id_reg;
  logic [3:0]          arb_reg;
  logic [NUM_PINS-1:0] pin_prev_reg;
  logic [NUM_PINS-1:0] pend_reg;
  logic                busy_reg;
  logic [PIN_W-1:0]    cur_reg;
  logic [31:0]         rdata_reg;
  ioird_msg_t          msg_reg;

  function automatic logic is_level(input logic [63:0] e);
    // non-maskable is forced to edge handling
    is_level = e[F_TRIG] && (ioird_dmode_t'(e[10:8]) != IOIRD_DM_NMI);
  endfunction

  function automatic ioird_msg_t make_msg(input logic [63:0] e);
    make_msg.logical = e[F_DMODE_SEL];
    make_msg.dest    = e[F_DMODE_SEL] ? e[63:56] : {4'h0, e[59:56]};
    make_msg.dmode   = ioird_dmode_t'(e[10:8]);
    make_msg.level   = is_level(e);
    make_msg.vector  = e[7:0];
  endfunction

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire       wr_index  = cpu_i.wr && cpu_i.addr == ADDR_INDEX;
  wire       wr_data   = cpu_i.wr && cpu_i.addr == ADDR_DATA;
  wire       wr_eos    = cpu_i.wr && cpu_i.addr == ADDR_EOS;
  wire       in_table  = index_reg >= IDX_TABLE_BASE && index_reg <= IDX_TABLE_LAST;
  wire [7:0] tbl_off   = index_reg - IDX_TABLE_BASE;
  wire [PIN_W-1:0] sel = tbl_off[PIN_W:1];
  wire       sel_high  = tbl_off[0];
  wire       eos_hit   = wr_eos || eos_valid_i;
  wire [7:0] eos_vec   = wr_eos ? cpu_i.wdata[7:0] : eos_vector_i;

  // polarity-corrected pin level
  logic [NUM_PINS-1:0] pin_act;
  logic [NUM_PINS-1:0] trig;
  always_comb
  begin
    for (int i = 0; i < NUM_PINS; i++)
    begin
      pin_act[i] = irq_pin_i[i] ^ entry_reg[i][F_POL];
      if (is_level(entry_reg[i]))
        trig[i] = pin_act[i] && !entry_reg[i][F_RACC];
      else
        trig[i] = pin_act[i] && !pin_prev_reg[i];
      trig[i] = trig[i] && !entry_reg[i][F_MASK];
    end
  end

  // lowest pending pin goes next
  logic             any_pend;
  logic [PIN_W-1:0] next_pin;
  always_comb
  begin
    any_pend = 1'b0;
    next_pin = '0;
    for (int i = NUM_PINS - 1; i >= 0; i--)
    begin
      if (pend_reg[i] && !entry_reg[i][F_MASK])
      begin
        any_pend = 1'b1;
        next_pin = PIN_W'(i);
      end
    end
  end

  wire [31:0] id_word  = {4'h0, id_reg, 24'h0};
  wire [31:0] arb_word = {4'h0, arb_reg, 24'h0};
  wire [63:0] sel_ent  = entry_reg[sel];
  wire [31:0] tbl_word = sel_high ? sel_ent[63:32] : sel_ent[31:0];
  wire [31:0] ind_word = (index_reg == IDX_ID)  ? id_word  :
                         (index_reg == IDX_VER) ? VER_VALUE :
                         (index_reg == IDX_ARB) ? arb_word :
                         in_table               ? tbl_word : 32'h0;
  wire [31:0] rdata_next = (cpu_i.addr == ADDR_INDEX) ? {24'h0, index_reg} :
                           (cpu_i.addr == ADDR_DATA)  ? ind_word : 32'h0;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      index_reg <= '0;
      id_reg    <= '0;
      arb_reg   <= '0;
      rdata_reg <= '0;
    end
    else
    begin
      if (wr_index)
        index_reg <= cpu_i.wdata[7:0];
      if (wr_data && index_reg == IDX_ID)
      begin
        id_reg  <= cpu_i.wdata[ID_MSB:ID_LSB];
        arb_reg <= cpu_i.wdata[ID_MSB:ID_LSB];
      end
      else if (arb_won_i)
        arb_reg <= '0;
      if (cpu_i.rd)
        rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      for (int i = 0; i < NUM_PINS; i++)
        entry_reg[i] <= {47'h0, 1'b1, 16'h0};
      pin_prev_reg <= '0;
      pend_reg     <= '0;
      busy_reg     <= 1'b0;
      cur_reg      <= '0;
      msg_reg      <= '0;
    end
    else
    begin
      // software write first, so the hardware-owned bits assigned below win
      if (wr_data && in_table)
      begin
        if (sel_high)
          entry_reg[sel][63:32] <= cpu_i.wdata & HIGH_WMASK;
        else
          entry_reg[sel][31:0] <= (cpu_i.wdata & LOW_WMASK) |
                                  (entry_reg[sel][31:0] & ~LOW_WMASK);
      end
      pin_prev_reg <= pin_act;
      for (int i = 0; i < NUM_PINS; i++)
      begin
        if (entry_reg[i][F_MASK] && !(busy_reg && cur_reg == PIN_W'(i)))
          pend_reg[i] <= 1'b0;
        else if (trig[i] && !pend_reg[i])
          pend_reg[i] <= 1'b1;
        if (eos_hit && entry_reg[i][7:0] == eos_vec)
          entry_reg[i][F_RACC] <= 1'b0;
        entry_reg[i][F_DSTAT] <= pend_reg[i];
      end
      if (!busy_reg && any_pend)
      begin
        busy_reg <= 1'b1;
        cur_reg  <= next_pin;
        msg_reg  <= make_msg(entry_reg[next_pin]);
      end
      else if (busy_reg && msg_sent_i)
      begin
        busy_reg <= 1'b0;
        pend_reg[cur_reg] <= 1'b0;
        if (msg_accepted_i && msg_reg.level)
          entry_reg[cur_reg][F_RACC] <= 1'b1;
      end
    end
  end

  assign rdata_o     = rdata_reg;
  assign msg_o       = msg_reg;
  assign msg_valid_o = busy_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_arb_reload: assert property (
    @(posedge clk_i) disable iff (reset_i)
    wr_data && index_reg == IDX_ID |=> arb_reg == $past(cpu_i.wdata[ID_MSB:ID_LSB]))
    else $error("arbitration id not reloaded");

  a_arb_zero: assert property (
    @(posedge clk_i) disable iff (reset_i)
    arb_won_i && !wr_data |=> arb_reg == 4'h0)
    else $error("arbitration winner not zero");

  a_send_hold: assert property (
    @(posedge clk_i) disable iff (reset_i)
    busy_reg && !msg_sent_i |=> busy_reg && cur_reg == $past(cur_reg))
    else $error("message dropped before acknowledge");

  a_mask_block: assert property (
    @(posedge clk_i) disable iff (reset_i)
    entry_reg[0][F_MASK] && !(busy_reg && cur_reg == '0) |=> !pend_reg[0])
    else $error("masked pin held pending");

  a_racc_set: assert property (
    @(posedge clk_i) disable iff (reset_i)
    busy_reg && msg_sent_i && msg_accepted_i && msg_reg.level && !eos_hit
    |=> entry_reg[$past(cur_reg)][F_RACC])
    else $error("remote accepted not set");

  a_dstat_track: assert property (
    @(posedge clk_i) disable iff (reset_i)
    pend_reg[1] |=> entry_reg[1][F_DSTAT])
    else $error("delivery status not shown");

  a_msg_hold: assert property (
    @(posedge clk_i) disable iff (reset_i)
    busy_reg && !msg_sent_i |=> msg_reg == $past(msg_reg))
    else $error("offered message changed before acknowledge");

  a_inflight_pend: assert property (
    @(posedge clk_i) disable iff (reset_i)
    busy_reg |-> pend_reg[cur_reg])
    else $error("in-flight pin lost its pending state");

  a_sent_release: assert property (
    @(posedge clk_i) disable iff (reset_i)
    busy_reg && msg_sent_i |=> !busy_reg && !pend_reg[$past(cur_reg)])
    else $error("pin not released after acknowledge");

  a_nmi_edge: assert property (
    @(posedge clk_i) disable iff (reset_i)
    busy_reg && msg_reg.dmode == IOIRD_DM_NMI |-> !msg_reg.level)
    else $error("non-maskable message sent as level");

  a_phys_dest: assert property (
    @(posedge clk_i) disable iff (reset_i)
    busy_reg && !msg_reg.logical |-> msg_reg.dest[7:4] == 4'h0)
    else $error("physical destination wider than four bits");

  a_arb_ro: assert property (
    @(posedge clk_i) disable iff (reset_i)
    wr_data && index_reg == IDX_ARB && !arb_won_i |=> arb_reg == $past(arb_reg))
    else $error("arbitration id written by software");

  a_arb_reserved: assert property (
    @(posedge clk_i) disable iff (reset_i)
    cpu_i.rd && cpu_i.addr == ADDR_DATA && index_reg == IDX_ARB
    |=> rdata_reg[31:28] == 4'h0 && rdata_reg[23:0] == 24'h0)
    else $error("arbitration reserved bits not zero");

  a_tbl_reserved: assert property (
    @(posedge clk_i) disable iff (reset_i)
    wr_data && in_table && sel_high |=> entry_reg[$past(sel)][55:32] == 24'h0)
    else $error("reserved entry bits took a write");

  // one copy of each property below for every table entry; a_mask_block and a_dstat_track above cover pins 0 and 1 only
  for (genvar g = 0; g < NUM_PINS; g++)
  begin : g_pin_chk
    a_eos_clear: assert property (
      @(posedge clk_i) disable iff (reset_i)
      eos_hit && entry_reg[g][7:0] == eos_vec && !(busy_reg && msg_sent_i)
      |=> !entry_reg[g][F_RACC])
      else $error("end of service did not clear");

    a_level_quiet: assert property (
      @(posedge clk_i) disable iff (reset_i)
      is_level(entry_reg[g]) && entry_reg[g][F_RACC] && !pend_reg[g] |=> !pend_reg[g])
      else $error("level resent while accepted");

    a_dstat_idle: assert property (
      @(posedge clk_i) disable iff (reset_i)
      !pend_reg[g] |=> !entry_reg[g][F_DSTAT])
      else $error("delivery status set while idle");

    a_racc_hold: assert property (
      @(posedge clk_i) disable iff (reset_i)
      entry_reg[g][F_RACC] && !eos_hit |=> entry_reg[g][F_RACC])
      else $error("remote accepted cleared without end of service");
  end

endmodule

/* File: design/ioird_pkg.sv */
package ioird_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int          NUM_PINS       = 24;
  localparam int          PIN_W          = 5;
  localparam logic [7:0]  IDX_ID         = 8'h00;
  localparam logic [7:0]  IDX_VER        = 8'h01;
  localparam logic [7:0]  IDX_ARB        = 8'h02;
  localparam logic [7:0]  IDX_TABLE_BASE = 8'h10;
  localparam logic [7:0]  IDX_TABLE_LAST = 8'h3f;

  // ----------------------------------------------------------------
  // direct window offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADDR_INDEX     = 8'h00;
  localparam logic [7:0]  ADDR_DATA      = 8'h10;
  localparam logic [7:0]  ADDR_EOS       = 8'h40;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int          ID_LSB         = 24;
  localparam int          ID_MSB         = 27;
  localparam int          F_MASK         = 16;
  localparam int          F_TRIG         = 15;
  localparam int          F_RACC         = 14;
  localparam int          F_POL          = 13;
  localparam int          F_DSTAT        = 12;
  localparam int          F_DMODE_SEL    = 11;
  localparam logic [31:0] LOW_WMASK      = 32'h0001_afff;
  localparam logic [31:0] HIGH_WMASK     = 32'hff00_0000;
  localparam logic [31:0] ID_WMASK       = 32'h0f00_0000;
  localparam logic [31:0] VER_VALUE      = 32'h0017_0011;  // arbitrary version value

  typedef enum logic [2:0] {
    IOIRD_DM_FIXED  = 3'h0,
    IOIRD_DM_LOWEST = 3'h1,
    IOIRD_DM_SMR    = 3'h2,
    IOIRD_DM_RSVD   = 3'h3,
    IOIRD_DM_NMI    = 3'h4,
    IOIRD_DM_INIT   = 3'h5,
    IOIRD_DM_RSV6   = 3'h6,
    IOIRD_DM_RSV7   = 3'h7
  } ioird_dmode_t;

  // message handed to the bus unit
  typedef struct packed {
    logic [7:0]   dest;
    logic         logical;
    ioird_dmode_t dmode;
    logic         level;
    logic [7:0]   vector;
  } ioird_msg_t;

  // software access on the direct window
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } ioird_cpu_t;

endpackage

/* File: dv/ioird_bus_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// bus unit and local unit stand-in
// ----------------------------------------------------------------
// acknowledges each offered message after delay_i idle cycles, so a slow
// bus can hold a message up for as long as a scenario needs
module ioird_bus_model
  import ioird_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       msg_valid_i,
  input  wire logic [7:0] delay_i,
  input  wire logic       accept_i,
  output logic            msg_sent_o,
  output logic            msg_accepted_o,
  output int              sent_count_o
);
  logic [7:0] wait_reg;

  assign msg_accepted_o = msg_sent_o & accept_i;

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      wait_reg     <= 8'h00;
      msg_sent_o   <= 1'b0;
      sent_count_o <= 0;
    end
    else if (!msg_valid_i || msg_sent_o)
    begin
      wait_reg   <= 8'h00;
      msg_sent_o <= 1'b0;
    end
    else if (wait_reg >= delay_i)
    begin
      msg_sent_o   <= 1'b1;
      sent_count_o <= sent_count_o + 1;
    end
    else
      wait_reg <= wait_reg + 8'h01;
  end
endmodule

/* File: dv/io_interrupt_redirection_test.sv */
`timescale 1ns/1ps
module io_interrupt_redirection_test;
  import ioird_pkg::*;
  logic                clk_i = 1'b0;
  logic                reset_i = 1'b1;
  ioird_cpu_t          cpu_i = '0;
  logic [31:0]         rdata_o;
  logic [NUM_PINS-1:0] irq_pin_i = '0;
  ioird_msg_t          msg_o;
  logic                msg_valid_o;
  logic                msg_sent_i;
  logic                msg_accepted_i;
  logic                arb_won_i = 1'b0;
  logic                eos_valid_i = 1'b0;
  logic [7:0]          eos_vector_i = 8'h00;
  logic [7:0]          dly = 8'h02;
  int                  n_sent;
  int                  n_errors = 0;
  int                  compares = 0;
  int                  seed = 32'h01fe;

  ioird_core i_ioird_core (.clk_i(clk_i), .reset_i(reset_i), .cpu_i(cpu_i), .rdata_o(rdata_o),
    .irq_pin_i(irq_pin_i), .msg_o(msg_o), .msg_valid_o(msg_valid_o), .msg_sent_i(msg_sent_i),
    .msg_accepted_i(msg_accepted_i), .arb_won_i(arb_won_i), .eos_valid_i(eos_valid_i),
    .eos_vector_i(eos_vector_i));
  ioird_bus_model i_ioird_bus_model (.clk_i(clk_i), .reset_i(reset_i),
    .msg_valid_i(msg_valid_o), .delay_i(dly), .accept_i(1'b1), .msg_sent_o(msg_sent_i),
    .msg_accepted_o(msg_accepted_i), .sent_count_o(n_sent));

  initial
    forever #4 clk_i = ~clk_i;

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input logic w, input logic r, input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    #1 cpu_i = '{wr: w, rd: r, addr: a, wdata: v};
    @(posedge clk_i);
    #1 cpu_i = '0;
  endtask
  task automatic wr(input logic [7:0] i, input logic [31:0] v);
    cyc(1'b1, 1'b0, ADDR_INDEX, {24'h0, i});
    cyc(1'b1, 1'b0, ADDR_DATA, v);
  endtask
  task automatic rd(input logic [7:0] i, output logic [31:0] v);
    cyc(1'b1, 1'b0, ADDR_INDEX, {24'h0, i});
    cyc(1'b0, 1'b1, ADDR_DATA, 32'h0);
    v = rdata_o;
  endtask
  // bounded wait for the offered-message level
  task automatic wait_for(input logic lvl);
    for (int i = 0; i < 200 && msg_valid_o !== lvl; i++)
    begin
      @(posedge clk_i);
      #1;
    end
    if (msg_valid_o !== lvl)
    begin
      n_errors++;
      stop_test();
    end
  endtask
  task automatic eos(input logic [7:0] v);
    @(posedge clk_i);
    #1 eos_valid_i = 1'b1;
    eos_vector_i = v;
    @(posedge clk_i);
    #1 eos_valid_i = 1'b0;
  endtask
  // non-maskable is sent as edge whatever bit 15 says
  function automatic logic [31:0] exp_msg(input logic [31:0] l, input logic [31:0] h);
    return {11'h0, h[31:24], l[11:8], l[15] && l[10:8] != 3'h4, l[7:0]};
  endfunction

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial
  begin
    logic [31:0] d, lo, hi, r;
    logic [2:0]  m;
    int          k0;
    repeat (6) @(posedge clk_i);
    #1 reset_i = 1'b0;
    for (int n = 0; n < NUM_PINS; n += 7)
    begin
      rd(IDX_TABLE_BASE + 8'(2 * n), d);
      chk(d, 32'h0001_0000);
    end
    r = $random(seed);
    lo = {4'h0, r[3:1], 1'b1, 24'h0};
    wr(IDX_ID, lo | 32'h00ab_cdef);
    rd(IDX_ARB, d);
    chk(d, lo);
    @(posedge clk_i);
    #1 arb_won_i = 1'b1;
    @(posedge clk_i);
    #1 arb_won_i = 1'b0;
    wr(IDX_ARB, 32'hffff_ffff);
    rd(IDX_ARB, d);
    chk(d, 32'h0);
    for (int j = 0; j < 5; j++)
    begin
      r = $random(seed);
      m = 3'(j + (j > 2));
      dly = {5'h0, r[19:17]};
      lo = {16'h0, m == 3'h4, 3'h0, r[16], m, 8'h10 + 8'(r[15:0] % 16'd239)};
      hi = r[16] ? {r[31:24], 24'h0} : {4'h0, r[27:24], 24'h0};
      wr(IDX_TABLE_BASE + 8'(2 * j + 3), hi);
      wr(IDX_TABLE_BASE + 8'(2 * j + 2), lo);
      irq_pin_i[j + 1] = 1'b1;
      wait_for(1'b1);
      chk({11'h0, msg_o}, exp_msg(lo, hi));
      wait_for(1'b0);
      irq_pin_i[j + 1] = 1'b0;
    end
    dly = 8'd40;
    wr(IDX_TABLE_BASE, 32'h0000_0031);
    k0 = n_sent;
    irq_pin_i[0] = 1'b1;
    wait_for(1'b1);
    irq_pin_i[0] = 1'b0;
    @(posedge clk_i);
    #1 irq_pin_i[0] = 1'b1;
    rd(IDX_TABLE_BASE, d);
    chk(d, 32'h0000_1031);
    wait_for(1'b0);
    repeat (10) @(posedge clk_i);
    rd(IDX_TABLE_BASE, d);
    chk(d, 32'h0000_0031);
    chk(32'(n_sent - k0), 32'h1);
    chk({31'h0, msg_valid_o}, 32'h0);
    dly = 8'h01;
    wr(IDX_TABLE_BASE + 8'h0c, 32'h0001_5055);
    rd(IDX_TABLE_BASE + 8'h0c, d);
    chk(d, 32'h0001_0055);
    k0 = n_sent;
    irq_pin_i[6] = 1'b1;
    repeat (10) @(posedge clk_i);
    #1 irq_pin_i[6] = 1'b0;
    wr(IDX_TABLE_BASE + 8'h0c, 32'h0000_0055);
    repeat (10) @(posedge clk_i);
    #1 chk(32'(n_sent - k0), 32'h0);
    wr(IDX_TABLE_BASE + 8'h0e, 32'h0000_8066);
    irq_pin_i[7] = 1'b1;
    wait_for(1'b1);
    chk({11'h0, msg_o}, exp_msg(32'h0000_8066, 32'h0));
    wait_for(1'b0);
    k0 = n_sent;
    wr(IDX_TABLE_BASE + 8'h0e, 32'h0001_8066);
    rd(IDX_TABLE_BASE + 8'h0e, d);
    chk(d, 32'h0001_c066);
    wr(IDX_TABLE_BASE + 8'h0e, 32'h0000_8066);
    repeat (10) @(posedge clk_i);
    #1 chk(32'(n_sent - k0), 32'h0);
    irq_pin_i[7] = 1'b0;
    eos(8'h67);
    rd(IDX_TABLE_BASE + 8'h0e, d);
    chk(d, 32'h0000_c066);
    eos(8'h66);
    rd(IDX_TABLE_BASE + 8'h0e, d);
    chk(d, 32'h0000_8066);
    irq_pin_i[7] = 1'b1;
    wait_for(1'b1);
    wait_for(1'b0);
    irq_pin_i[7] = 1'b0;
    rd(IDX_TABLE_BASE + 8'h0e, d);
    chk(d, 32'h0000_c066);
    cyc(1'b1, 1'b0, ADDR_EOS, 32'hffff_ff66);
    rd(IDX_TABLE_BASE + 8'h0e, d);
    chk(d, 32'h0000_8066);
    irq_pin_i[23] = 1'b1;
    wr(IDX_TABLE_BASE + 8'h2e, 32'h0000_2077);
    // one quiet cycle under the new polarity, so the fall reads as an edge
    @(posedge clk_i);
    #1 irq_pin_i[23] = 1'b0;
    wait_for(1'b1);
    chk({11'h0, msg_o}, exp_msg(32'h0000_2077, 32'h0));
    wait_for(1'b0);
    stop_test();
  end
endmodule
